//--- luma_cfg.svh
`ifndef LUMA_CFG_SVH
`define LUMA_CFG_SVH

// Register sub-addresses
`define LUMA_GAMMA_BASE 8'h26
`define LUMA_GAMMA_COUNT 8'h0E
`define LUMA_BRIGHT_ADDR 8'h34
`define LUMA_AUXCLK_ADDR 8'h35

// Field positions and reset values
`define LUMA_AUXCLK_EN_BIT 1
`define LUMA_AUXCLK_RESET 8'h70
`define LUMA_POINT_STEP 32

// Curve shape
`define LUMA_CURVE_POINTS 7
`define LUMA_KNOT_LOW 8'h10
`define LUMA_KNOT_LAST 8'hE0
`define LUMA_KNOT_HIGH 8'hF0
`define LUMA_SHIFT_WIDE 5
`define LUMA_SHIFT_NARROW 4

// Brightness divider timing
`define LUMA_DIV_STEPS 8

`endif

//--- luma_pkg.sv
package luma_pkg;

    // One luma or chroma sample
    typedef logic [7:0] sample_t;

    // Brightness divider sequencer
    typedef enum logic [1:0]
    {
        DIV_IDLE = 2'b01,
        DIV_RUN = 2'b10
    } div_state_t;

endpackage : luma_pkg

//--- gamma_point_mem.sv
`timescale 1ns/1ns
`default_nettype none
`include "luma_cfg.svh"

module gamma_point_mem #(
    parameter int NUM_POINTS = 14,
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [3:0] wr_index_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    // Registered read port for software
    input wire logic [3:0] rd_index_i,
    output logic [WIDTH-1:0] rd_data_o,
    // All points, straight from the flip-flops
    output logic [NUM_POINTS*WIDTH-1:0] points_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic [WIDTH-1:0] mem [NUM_POINTS];

    // Points reset to a straight line so an unprogrammed curve is harmless
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            for (int i = 0; i < NUM_POINTS; i++)
                mem[i] <= WIDTH'(((i % `LUMA_CURVE_POINTS) + 1) * `LUMA_POINT_STEP);
        end
        else if (wr_en_i && (int'(wr_index_i) < NUM_POINTS))
        begin
            mem[wr_index_i] <= wr_data_i;
        end
    end

    // Read data leaves through a register
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rd_data_o <= '0;
        else if (int'(rd_index_i) < NUM_POINTS)
            rd_data_o <= mem[rd_index_i];
        else
            rd_data_o <= '0;
    end

    // Flatten for the interpolator
    always_comb
    begin
        for (int i = 0; i < NUM_POINTS; i++)
            points_o[i*WIDTH +: WIDTH] = mem[i];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_point_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wr_en_i && (int'(wr_index_i) < NUM_POINTS) |=> mem[$past(wr_index_i)] == $past(wr_data_i))
        else $error("gamma point not stored");

endmodule : gamma_point_mem

`default_nettype wire

//--- luma_gamma_brightness_aux_clock_pin.sv
`timescale 1ns/1ns
`default_nettype none
`include "luma_cfg.svh"

// Behaviour
// - Gamma touches luma only, chroma unaltered
// - Two curves held, exactly one applied
// - Fourteen writable 8-bit breakpoint registers
// - Breakpoints at 32,64,...,224 on 256 axis
// - Points 0,16,240,255 fixed
// - Linear interpolation between neighbouring breakpoints
// - Brightness register read-only, writes ignored
// - Brightness sums active video only
// - Brightness updates eight cycles after vsync falling edge
// - Enable bit drives 54 MHz on aux pin
// - Aux clock needs PLL on, oversampling on
module luma_gamma_brightness_aux_clock_pin
    import luma_pkg::*;
#(
    parameter int ACC_W = 28,
    parameter int CNT_W = 20
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Pixel stream in
    input wire logic pix_valid_i,
    input wire logic [7:0] luma_i,
    input wire logic [7:0] chroma_i,
    input wire logic active_i,
    input wire logic vsync_n_i,
    // Pixel stream out
    output logic pix_valid_o,
    output logic [7:0] luma_o,
    output logic [7:0] chroma_o,
    // Mode bits from elsewhere
    input wire logic gamma_enable_i,
    input wire logic gamma_curve_b_i,
    input wire logic pll_disable_bit_i,
    input wire logic oversample_enable_bit_i,
    // Clocks
    input wire logic pll_clk54_i,
    output logic aux_clock_pin_o,
    // Decoded register access
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rack_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    logic gamma_hit; // Address falls in the point bank
    logic [3:0] gamma_index; // Point number within the bank
    logic [8*14-1:0] points; // All fourteen points
    logic [7:0] mem_rdata; // Registered point readback
    logic [7:0] aux_clock_control; // Output clock register
    logic [7:0] average_brightness; // Field mean
    logic rd_q; // Read in flight
    logic rd_gamma_q; // Read targets the point bank
    logic [7:0] side_q; // Readback of the other registers

    always_comb
    begin
        gamma_hit = (reg_addr_i >= `LUMA_GAMMA_BASE) && (reg_addr_i < (`LUMA_GAMMA_BASE + `LUMA_GAMMA_COUNT));
        gamma_index = 4'(reg_addr_i - `LUMA_GAMMA_BASE);
    end

    gamma_point_mem #(
        .NUM_POINTS(14),
        .WIDTH(8)
    ) u_points (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .wr_en_i(reg_wr_i && gamma_hit),
        .wr_index_i(gamma_index),
        .wr_data_i(reg_wdata_i),
        .rd_index_i(gamma_index),
        .rd_data_o(mem_rdata),
        .points_o(points)
    );

    // Output clock register; all bits stored, only the enable acts
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            aux_clock_control <= `LUMA_AUXCLK_RESET;
        else if (reg_wr_i && (reg_addr_i == `LUMA_AUXCLK_ADDR))
            aux_clock_control <= reg_wdata_i;
    end

    // First read stage: pick the non-bank register, bank reads itself
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rd_q <= 1'b0;
            rd_gamma_q <= 1'b0;
            side_q <= 8'h00;
        end
        else
        begin
            rd_q <= reg_rd_i;
            rd_gamma_q <= gamma_hit;
            if (reg_addr_i == `LUMA_BRIGHT_ADDR)
                side_q <= average_brightness;
            else if (reg_addr_i == `LUMA_AUXCLK_ADDR)
                side_q <= aux_clock_control;
            else
                side_q <= 8'h00; // Unmapped reads as zero
        end
    end

    // Second read stage; two-cycle latency keeps the bank and the rest aligned
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            reg_rdata_o <= 8'h00;
            reg_rack_o <= 1'b0;
        end
        else
        begin
            reg_rack_o <= rd_q;
            if (rd_q)
                reg_rdata_o <= rd_gamma_q ? mem_rdata : side_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gamma interpolator
    logic [7:0] lo_y; // Output at left knot
    logic [7:0] hi_y; // Output at right knot
    logic [4:0] seg_off; // Distance from left knot
    logic seg_narrow; // Segment spans 16 codes, else 32
    logic bypass_seg; // Fixed identity region
    logic [3:0] base; // First point of the chosen curve
    logic [7:0] next_luma; // Curve output
    logic signed [9:0] diff; // Rise across the segment
    logic signed [15:0] prod; // Rise scaled by offset
    logic signed [15:0] step; // Rise at this sample
    logic [2:0] seg; // Which 32-wide slot

    always_comb
    begin
        base = gamma_curve_b_i ? 4'h7 : 4'h0;
        seg = luma_i[7:5];
        lo_y = 8'h00;
        hi_y = 8'h00;
        seg_off = luma_i[4:0];
        seg_narrow = 1'b0;
        bypass_seg = 1'b0;
        // Knots outside 16..240 are fixed identity points
        if ((luma_i < `LUMA_KNOT_LOW) || (luma_i >= `LUMA_KNOT_HIGH))
        begin
            bypass_seg = 1'b1;
        end
        else if (seg == 3'd0)
        begin
            // 16 up to 32: fixed 16 to first point
            lo_y = `LUMA_KNOT_LOW;
            hi_y = points[8*base +: 8];
            seg_off = 5'(luma_i - `LUMA_KNOT_LOW);
            seg_narrow = 1'b1;
        end
        else if (seg == 3'd7)
        begin
            // 224 up to 240: last point to fixed 240
            lo_y = points[8*(base + 4'd6) +: 8];
            hi_y = `LUMA_KNOT_HIGH;
            seg_off = 5'(luma_i - `LUMA_KNOT_LAST);
            seg_narrow = 1'b1;
        end
        else
        begin
            // Knot k-1 sits at 32*k
            lo_y = points[8*(base + 4'(seg) - 4'd1) +: 8];
            hi_y = points[8*(base + 4'(seg)) +: 8];
        end
        diff = 10'(signed'({2'b00, hi_y}) - signed'({2'b00, lo_y}));
        prod = 16'(diff * signed'({1'b0, seg_off}));
        // Spans are powers of two, so the divide is a shift
        step = seg_narrow ? (prod >>> `LUMA_SHIFT_NARROW) : (prod >>> `LUMA_SHIFT_WIDE);
        next_luma = bypass_seg ? luma_i : 8'(16'(signed'({8'h00, lo_y})) + step);
    end

    // One register stage; chroma rides alongside untouched
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pix_valid_o <= 1'b0;
            luma_o <= 8'h00;
            chroma_o <= 8'h00;
        end
        else
        begin
            pix_valid_o <= pix_valid_i;
            if (pix_valid_i)
            begin
                luma_o <= gamma_enable_i ? next_luma : luma_i;
                chroma_o <= chroma_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Brightness accumulation
    logic vsync_q; // Previous vsync level
    logic vsync_fall; // Start of vertical sync
    logic [ACC_W-1:0] acc_sum; // Luma sum this field
    logic [CNT_W-1:0] acc_count; // Samples this field
    logic take; // Sample counts toward the mean

    always_comb
    begin
        vsync_fall = vsync_q && !vsync_n_i;
        take = pix_valid_i && active_i;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            vsync_q <= 1'b1;
        else
            vsync_q <= vsync_n_i;
    end

    // A sample in the edge cycle opens the next field
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            acc_sum <= '0;
            acc_count <= '0;
        end
        else if (vsync_fall)
        begin
            acc_sum <= take ? ACC_W'(luma_i) : '0;
            acc_count <= take ? CNT_W'(1) : '0;
        end
        else if (take)
        begin
            acc_sum <= acc_sum + ACC_W'(luma_i);
            acc_count <= acc_count + CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mean by restoring division; the quotient never exceeds eight bits
    div_state_t div_state; // Sequencer state
    logic [ACC_W-1:0] div_rem; // Partial remainder
    logic [CNT_W-1:0] div_den; // Sample count
    logic [2:0] div_step; // Quotient bit in work
    logic [7:0] div_q; // Quotient so far
    logic [ACC_W+7:0] den_shift; // Count aligned to this bit
    logic div_bit; // This quotient bit
    logic [7:0] next_q; // Quotient with this bit

    always_comb
    begin
        den_shift = (ACC_W + 8)'(div_den) << div_step;
        // Empty field gives zero rather than all ones
        div_bit = (div_den != '0) && ({8'h00, div_rem} >= den_shift);
        next_q = div_q | (8'(div_bit) << div_step);
    end

    // A new edge restarts the divider; fields are far longer than eight cycles
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            div_state <= DIV_IDLE;
            div_rem <= '0;
            div_den <= '0;
            div_step <= 3'd0;
            div_q <= 8'h00;
        end
        else if (vsync_fall)
        begin
            div_state <= DIV_RUN;
            div_rem <= acc_sum;
            div_den <= acc_count;
            div_step <= 3'(`LUMA_DIV_STEPS - 1);
            div_q <= 8'h00;
        end
        else
        begin
            unique case (div_state)
                DIV_IDLE:
                begin
                    div_state <= DIV_IDLE;
                end
                DIV_RUN:
                begin
                    if (div_bit)
                        div_rem <= div_rem - ACC_W'(den_shift);
                    div_q <= next_q;
                    div_step <= div_step - 3'd1;
                    if (div_step == 3'd0)
                        div_state <= DIV_IDLE;
                end
                default:
                begin
                    div_state <= DIV_IDLE;
                end
            endcase
        end
    end

    // Only the divider writes here; software writes never reach it
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            average_brightness <= 8'h00;
        else if ((div_state == DIV_RUN) && (div_step == 3'd0) && !vsync_fall)
            average_brightness <= next_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auxiliary clock gate; a plain AND may clip a pulse when the enable moves
    logic aux_allow; // Enable qualified by PLL state

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            aux_allow <= 1'b0;
        else
            aux_allow <= aux_clock_control[`LUMA_AUXCLK_EN_BIT]
                && !pll_disable_bit_i && oversample_enable_bit_i;
    end

    assign aux_clock_pin_o = pll_clk54_i && aux_allow;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_chroma_pass: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pix_valid_i |=> chroma_o == $past(chroma_i))
        else $error("chroma altered");

    a_gamma_bypass: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pix_valid_i && !gamma_enable_i |=> luma_o == $past(luma_i))
        else $error("luma changed with gamma off");

    a_fixed_knots: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pix_valid_i && gamma_enable_i && ((luma_i == 8'h10) || (luma_i == 8'hF0) || (luma_i == 8'h00)
        || (luma_i == 8'hFF)) |=> luma_o == $past(luma_i))
        else $error("fixed curve point moved");

    a_break_hit: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pix_valid_i && gamma_enable_i && (luma_i == 8'h40)
        |=> luma_o == $past(points[8*(gamma_curve_b_i ? 8 : 1) +: 8]))
        else $error("breakpoint 64 wrong");

    a_curve_mid: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pix_valid_i && gamma_enable_i && (luma_i == 8'h50)
        |=> 9'(luma_o) * 2 >= $past(9'(lo_y) + 9'(hi_y)) - 9'd1
        && 9'(luma_o) * 2 <= $past(9'(lo_y) + 9'(hi_y)))
        else $error("midpoint not interpolated");

    a_active_only: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !active_i && !vsync_fall |=> $stable(acc_count) && $stable(acc_sum))
        else $error("blanking sample counted");

    a_div_run: assert property (@(posedge clk_i) disable iff (!resetn_i)
        vsync_fall ##1 !vsync_fall [*8] |-> ((div_state == DIV_RUN) && (div_step == 3'd0)) ##1 div_state == DIV_IDLE)
        else $error("divider did not finish in eight cycles");

    a_bright_ro: assert property (@(posedge clk_i) disable iff (!resetn_i)
        div_state == DIV_IDLE && !vsync_fall && reg_wr_i && (reg_addr_i == `LUMA_BRIGHT_ADDR)
        |=> $stable(average_brightness))
        else $error("brightness written by software");

    a_aux_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (pll_disable_bit_i || !oversample_enable_bit_i) |=> !aux_clock_pin_o)
        else $error("aux clock out while PLL not ready");

endmodule : luma_gamma_brightness_aux_clock_pin

`default_nettype wire

//--- luma_src_model.sv
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Upstream pixel source: stands in for the decoder feeding the luma block
module luma_src_model (
    // Clock
    input wire logic clk_i,
    // Pixel stream towards the block
    output logic pix_valid_o,
    output logic [7:0] luma_o,
    output logic [7:0] chroma_o,
    output logic active_o,
    output logic vsync_n_o
);
    // Quiet stream at time zero, sync inactive
    initial
    begin
        pix_valid_o = 1'b0;
        luma_o = 8'h00;
        chroma_o = 8'h00;
        active_o = 1'b0;
        vsync_n_o = 1'b1;
    end

    // One sample held across one rising edge; caller sits just after an edge
    task automatic send(input logic [7:0] y, input logic [7:0] c, input logic act);
        pix_valid_o = 1'b1;
        luma_o = y;
        chroma_o = c;
        active_o = act;
        @(posedge clk_i);
        #1;
    endtask : send

    // Gap: data shows the inverse so a stale sample is never taken for fresh
    task automatic idle(input int cycles);
        pix_valid_o = 1'b0;
        luma_o = ~luma_o;
        chroma_o = ~chroma_o;
        repeat (cycles)
        begin
            @(posedge clk_i);
            #1;
        end
    endtask : idle

    // Field boundary: sync low three cycles; call only while the stream is idle
    task automatic field_end();
        vsync_n_o = 1'b0;
        repeat (3)
        begin
            @(posedge clk_i);
            #1;
        end
        vsync_n_o = 1'b1;
    endtask : field_end
endmodule : luma_src_model

`default_nettype wire

//--- luma_gamma_brightness_aux_clock_pin_tb.sv
`timescale 1ns/1ns
`default_nettype none

module luma_gamma_brightness_aux_clock_pin_tb;
    // Stimulus and observed signals
    logic clk_i, resetn_i, gamma_enable_i, gamma_curve_b_i, pll_disable_bit_i;
    logic oversample_enable_bit_i, pll_clk54_i, reg_wr_i, reg_rd_i, reg_rack_o;
    logic pix_valid_i, active_i, vsync_n_i, pix_valid_o, aux_clock_pin_o;
    logic [7:0] luma_i, chroma_i, luma_o, chroma_o, reg_addr_i, reg_wdata_i, reg_rdata_o, rd;
    int n_errors, num_checks;
    // Curve A leans up, curve B falls in places to exercise negative slopes
    logic [7:0] pa[7] = '{8'h4C, 8'h78, 8'h96, 8'hAE, 8'hC4, 8'hD7, 8'hE8};
    logic [7:0] pb[7] = '{8'h28, 8'h1E, 8'h5A, 8'h80, 8'hC8, 8'h64, 8'h3C};
    // 64 lands on a breakpoint and 80 halfway into a segment, for the design's own checks
    int xs[19] = '{0, 15, 16, 17, 31, 32, 33, 63, 64, 80, 100, 128, 200, 223, 224, 230, 239, 240, 255};

    luma_src_model i_luma_src_model (.clk_i(clk_i), .pix_valid_o(pix_valid_i), .luma_o(luma_i),
        .chroma_o(chroma_i), .active_o(active_i), .vsync_n_o(vsync_n_i));

    luma_gamma_brightness_aux_clock_pin i_luma_gamma_brightness_aux_clock_pin (.clk_i(clk_i), .resetn_i(resetn_i),
        .pix_valid_i(pix_valid_i), .luma_i(luma_i), .chroma_i(chroma_i), .active_i(active_i),
        .vsync_n_i(vsync_n_i), .pix_valid_o(pix_valid_o), .luma_o(luma_o), .chroma_o(chroma_o),
        .gamma_enable_i(gamma_enable_i), .gamma_curve_b_i(gamma_curve_b_i),
        .pll_disable_bit_i(pll_disable_bit_i), .oversample_enable_bit_i(oversample_enable_bit_i),
        .pll_clk54_i(pll_clk54_i), .aux_clock_pin_o(aux_clock_pin_o), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .reg_rack_o(reg_rack_o));

    ////////////////////////////////////////////////////////////////////////////
    // Clocks: pixel clock, and an unrelated free-running stand-in for the PLL
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial
    begin
        pll_clk54_i = 1'b0;
        #4;
        forever #9 pll_clk54_i = ~pll_clk54_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic summarize();
        if (n_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : check

    // Write, then one idle cycle so the strobe is never reassigned in one step
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge clk_i);
        #1;
        reg_wr_i = 1'b0;
        @(posedge clk_i);
        #1;
    endtask : reg_write

    // Read with bounded wait; latency of the answer is checked too
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        int i;
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(posedge clk_i);
        #1;
        reg_rd_i = 1'b0;
        for (i = 0; i < 4 && reg_rack_o !== 1'b1; i++)
        begin
            @(posedge clk_i);
            #1;
        end
        if (reg_rack_o !== 1'b1)
        begin
            n_errors++;
            summarize();
        end
        // Answer stands one edge after the edge that took the strobe
        check(8'(i), 8'h01);
        d = reg_rdata_o;
        @(posedge clk_i);
        #1;
    endtask : reg_read

    // Expected curve output; knots 16 and 240 are fixed, identity outside
    function automatic logic [7:0] gamma_ref(input int x, input logic [7:0] p[7]);
        int lo, hi, off, sh, k;
        if (x < 16 || x >= 240)
            return 8'(x);
        if (x < 32)
        begin
            lo = 16;
            hi = p[0];
            off = x - 16;
            sh = 4;
        end
        else if (x >= 224)
        begin
            lo = p[6];
            hi = 240;
            off = x - 224;
            sh = 4;
        end
        else
        begin
            k = x / 32;
            lo = p[k - 1];
            hi = p[k];
            off = x - 32 * k;
            sh = 5;
        end
        k = lo + (((hi - lo) * off) >>> sh);
        return 8'(k);
    endfunction : gamma_ref

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs();
        for (int i = 0; i < 14; i++)
        begin
            reg_read(8'(8'h26 + i), rd);
            check(rd, 8'(32 * (i % 7 + 1)));
        end
        reg_read(8'h35, rd);
        check(rd, 8'h70);
        reg_read(8'h40, rd);
        check(rd, 8'h00);
        // Curve A and curve B written point by point in turn, all inside 16..240
        for (int i = 0; i < 7; i++)
        begin
            reg_write(8'(8'h26 + i), pa[i]);
            reg_write(8'(8'h2D + i), pb[i]);
        end
        for (int i = 0; i < 7; i++)
        begin
            reg_read(8'(8'h2D + i), rd);
            check(rd, pb[i]);
        end
        reg_write(8'h34, 8'hAA);
        reg_read(8'h34, rd);
        check(rd, 8'h00);
    endtask : t_regs

    // Bypass, curve A, curve B on back-to-back samples
    task automatic t_gamma();
        for (int m = 0; m < 3; m++)
        begin
            gamma_enable_i = (m != 0);
            gamma_curve_b_i = (m == 2);
            for (int i = 0; i < 19; i++)
            begin
                i_luma_src_model.send(8'(xs[i]), ~8'(xs[i]), 1'b0);
                check({7'h00, pix_valid_o}, 8'h01);
                check(chroma_o, ~8'(xs[i]));
                if (m == 0)
                    check(luma_o, 8'(xs[i]));
                else if (m == 1)
                    check(luma_o, gamma_ref(xs[i], pa));
                else
                    check(luma_o, gamma_ref(xs[i], pb));
            end
            i_luma_src_model.idle(2);
            check({7'h00, pix_valid_o}, 8'h00);
        end
    endtask : t_gamma

    // One field with blanking samples mixed in; result appears only after the fall
    task automatic t_bright();
        logic [7:0] ys[6] = '{8'h0A, 8'hFA, 8'hC8, 8'h4D, 8'hF0, 8'hFF};
        logic ac[6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        int sum, cnt;
        sum = 0;
        cnt = 0;
        i_luma_src_model.field_end();
        for (int i = 0; i < 6; i++)
        begin
            i_luma_src_model.send(ys[i], 8'h80, ac[i]);
            sum += ac[i] ? int'(ys[i]) : 0;
            cnt += ac[i] ? 1 : 0;
        end
        i_luma_src_model.idle(10);
        reg_read(8'h34, rd);
        check(rd, 8'h00);
        i_luma_src_model.field_end();
        i_luma_src_model.idle(8);
        reg_read(8'h34, rd);
        check(rd, 8'(sum / cnt));
    endtask : t_bright

    // Enable bit against each blocking condition
    task automatic t_aux();
        logic [2:0] combo[4] = '{3'b101, 3'b111, 3'b100, 3'b001};
        logic on;
        for (int c = 0; c < 4; c++)
        begin
            pll_disable_bit_i = combo[c][1];
            oversample_enable_bit_i = combo[c][0];
            reg_write(8'h35, {6'b011100, combo[c][2], 1'b0});
            on = combo[c] == 3'b101;
            @(posedge clk_i);
            #1;
            repeat (6)
            begin
                @(pll_clk54_i);
                #1;
                check({7'h00, aux_clock_pin_o}, {7'h00, pll_clk54_i & on});
            end
            reg_read(8'h35, rd);
            check(rd, {6'b011100, combo[c][2], 1'b0});
        end
    endtask : t_aux

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        n_errors = 0;
        num_checks = 0;
        resetn_i = 1'b0;
        gamma_enable_i = 1'b0;
        gamma_curve_b_i = 1'b0;
        pll_disable_bit_i = 1'b1;
        oversample_enable_bit_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        repeat (6) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        t_regs();
        t_gamma();
        t_bright();
        t_aux();
        summarize();
    end
endmodule : luma_gamma_brightness_aux_clock_pin_tb

`default_nettype wire
